// >>> hw/diup_pkg.sv
// package for the depth image udp packetizer: constants, layouts, state and helpers
package diup_pkg;

	// packet geometry
	localparam logic [10:0] DIUP_PKT_HDR_BYTES = 11'h020;
	localparam logic [10:0] DIUP_PKT_DATA_MAX = 11'h578;
	localparam logic [10:0] DIUP_PKT_TOTAL = 11'h598;
	localparam logic [31:0] DIUP_IMG_HDR_BYTES = 32'h00000040;

	// fixed header contents and offsets
	localparam logic [15:0] DIUP_PROTO_VERSION = 16'h0001;
	localparam logic [15:0] DIUP_IMG_MARK = 16'hffff;
	localparam logic [15:0] DIUP_IMG_REVISION = 16'h0003;
	localparam logic [31:0] DIUP_IH_CRC_FIRST = 32'h00000002;
	localparam logic [31:0] DIUP_IH_CRC_OFS = 32'h0000003e;
	localparam logic [7:0] DIUP_TEMP_OFFSET = 8'h32;

	// checksums
	localparam logic [31:0] DIUP_CRC32_POLY = 32'h04c11db7;
	localparam logic [31:0] DIUP_CRC32_SEED = 32'h0fffffff;
	localparam logic [15:0] DIUP_CRC16_POLY = 16'h1021;
	localparam logic [15:0] DIUP_CRC16_SEED = 16'h0000;

	// register offsets (byte addresses)
	localparam logic [7:0] DIUP_REG_CTRL = 8'h00;
	localparam logic [7:0] DIUP_REG_STATUS = 8'h04;
	localparam logic [7:0] DIUP_REG_DEST_IP = 8'h08;
	localparam logic [7:0] DIUP_REG_DEST_PORT = 8'h0c;
	localparam logic [7:0] DIUP_REG_IMG_DIMS = 8'h10;
	localparam logic [7:0] DIUP_REG_IMG_FORMAT = 8'h14;
	localparam logic [7:0] DIUP_REG_CODE_REV = 8'h18;
	localparam logic [7:0] DIUP_REG_ACTIVE_IP = 8'h1c;
	localparam logic [7:0] DIUP_REG_ACTIVE_PORT = 8'h20;

	// control register bit positions
	localparam int DIUP_CTRL_UDP = 0;
	localparam int DIUP_CTRL_TCP = 1;
	localparam int DIUP_CTRL_SKIP = 2;
	localparam int DIUP_CTRL_SAVE = 3;
	localparam int DIUP_CTRL_RECONNECT = 4;
	localparam int DIUP_CTRL_BUSY = 5;
	localparam int DIUP_CTRL_SAVED = 6;

	// reset values
	localparam logic [31:0] DIUP_DEST_IP_RST = 32'he0000001;
	localparam logic [15:0] DIUP_DEST_PORT_RST = 16'h2712;

	typedef enum logic [1:0] {DIUP_IDLE, DIUP_HEAD, DIUP_FILL, DIUP_SEND} diup_phase_type;

	typedef struct packed {
		diup_phase_type phase;
		logic udp_en;
		logic tcp_en;
		logic skip_check;
		logic [31:0] staged_ip;
		logic [15:0] staged_port;
		logic [31:0] saved_ip;
		logic [15:0] saved_port;
		logic saved_valid;
		logic [31:0] active_ip;
		logic [15:0] active_port;
		logic [15:0] pixel_columns;
		logic [15:0] pixel_rows;
		logic [7:0] channel_count;
		logic [7:0] pixel_byte_size;
		logic [15:0] payload_layout_setting;
		logic [15:0] code_revision_register;
		logic [31:0] prdata;
		logic pslverr;
		logic [31:0] stamp;
		logic [7:0] main_board_temperature;
		logic [7:0] illumination_board_temperature;
		logic [31:0] frame_total_bytes;
		logic [31:0] frame_offset;
		logic [15:0] frame_sequence_count;
		logic [15:0] packet_sequence_number;
		logic [10:0] packet_payload_length;
		logic [10:0] idx;
		logic [31:0] packet_checksum;
		logic [15:0] header_checksum;
		logic [7:0] out_data;
		logic out_valid;
		logic out_sop;
		logic out_last;
	} diup_state_type;

	// one byte of crc-32, msb first, no reflection
	function automatic logic [31:0] diup_crc32_step(input logic [31:0] c, input logic [7:0] d);
		logic [31:0] r;
		r = c;
		for (int b = 7; b >= 0; b--)
		begin
			r = (r[31] ^ d[b]) ? ((r << 1) ^ DIUP_CRC32_POLY) : (r << 1);
		end
		return r;
	endfunction

	// one byte of crc-ccitt, msb first
	function automatic logic [15:0] diup_crc16_step(input logic [15:0] c, input logic [7:0] d);
		logic [15:0] r;
		r = c;
		for (int b = 7; b >= 0; b--)
		begin
			r = (r[15] ^ d[b]) ? ((r << 1) ^ DIUP_CRC16_POLY) : (r << 1);
		end
		return r;
	endfunction

	// byte i of a 64-byte vector, byte 0 in the top bits
	function automatic logic [7:0] diup_pick_byte(input logic [511:0] v, input logic [5:0] i);
		logic [511:0] t;
		t = v << {i, 3'b000};
		return t[511:504];
	endfunction

endpackage

// >>> hw/diup_packetizer.sv
// depth image udp packetizer: apb registers, header builder, packet buffer and byte stream out
`timescale 1ns/1ps
`default_nettype none
module diup_packetizer
	import diup_pkg::*;
(
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_b,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// frame capture side
	input wire logic frame_start,
	input wire logic [31:0] frame_timestamp_us,
	input wire logic [7:0] main_temp_celsius,
	input wire logic [7:0] illum_temp_celsius,
	// pixel byte stream in
	input wire logic [7:0] pix_data,
	input wire logic pix_valid,
	output logic pix_ready,
	// packet byte stream out
	output logic [7:0] out_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic out_sop,
	output logic out_last,
	// network settings in force
	output logic udp_stream_enable,
	output logic tcp_listen_enable,
	output logic [31:0] dest_ip,
	output logic [15:0] dest_port
);

	diup_state_type s;
	diup_state_type next_s;

	// payload store for one packet; header bytes are rebuilt, never stored
	logic [7:0] pkt_mem [0:1399];
	logic mem_we;
	logic [10:0] mem_waddr;
	logic [7:0] mem_wdata;
	logic [7:0] mem_rdata;

	logic [511:0] img_vec;
	logic [511:0] head_vec_zero;
	logic [511:0] head_vec_final;
	logic [255:0] head_fields;
	logic [7:0] fill_byte;
	logic fill_from_header;
	logic fill_ok;
	logic load_ok;
	logic [10:0] send_end;
	logic [31:0] remain;
	logic [10:0] next_len;
	logic [31:0] image_bytes;
	logic [31:0] rd_value;
	logic rd_mapped;

	// apb answers in the access phase right after setup
	assign pready = psel & penable;
	assign prdata = s.prdata;
	assign pslverr = s.pslverr;

	assign out_data = s.out_data;
	assign out_valid = s.out_valid;
	assign out_sop = s.out_sop;
	assign out_last = s.out_last;
	assign udp_stream_enable = s.udp_en;
	assign tcp_listen_enable = s.tcp_en;
	assign dest_ip = s.active_ip;
	assign dest_port = s.active_port;

	// image header, byte 0 in the top bits, big-endian fields, reserved zero
	assign img_vec = {DIUP_IMG_MARK, DIUP_IMG_REVISION,
		s.pixel_columns, s.pixel_rows,
		s.channel_count, s.pixel_byte_size, s.payload_layout_setting,
		s.stamp,
		s.frame_sequence_count,
		64'h0000000000000000,
		s.main_board_temperature, s.illumination_board_temperature,
		s.code_revision_register,
		256'h0, s.header_checksum};

	// packet header without the checksum word
	assign head_fields = {DIUP_PROTO_VERSION,
		s.frame_sequence_count,
		s.packet_sequence_number,
		5'h00, s.packet_payload_length,
		s.frame_total_bytes,
		32'h00000000,
		31'h00000000, s.skip_check,
		96'h0};
	// checksum field counts as zero while the checksum itself is formed
	assign head_vec_zero = {head_fields, 256'h0};
	assign head_vec_final = {head_fields[255:160], s.packet_checksum, head_fields[127:0], 256'h0};

	// payload byte source: image header first, then the pixel stream
	assign fill_from_header = s.frame_offset < DIUP_IMG_HDR_BYTES;
	assign fill_byte = fill_from_header ? diup_pick_byte(img_vec, s.frame_offset[5:0]) : pix_data;
	assign fill_ok = fill_from_header | pix_valid;
	assign pix_ready = (s.phase == DIUP_FILL) & ~fill_from_header;

	// output register may take a byte when empty or being drained
	assign load_ok = ~s.out_valid | out_ready;
	assign send_end = DIUP_PKT_HDR_BYTES + s.packet_payload_length - 11'h001;
	assign mem_rdata = pkt_mem[11'(s.idx - DIUP_PKT_HDR_BYTES)];
	// widen each factor first so large frames do not wrap at 16 bits
	assign image_bytes = 32'(s.pixel_columns) * 32'(s.pixel_rows) * 32'(s.channel_count) * 32'(s.pixel_byte_size);

	// next packet length from bytes still to go
	assign remain = s.frame_total_bytes - s.frame_offset;
	assign next_len = (remain > 32'(DIUP_PKT_DATA_MAX)) ? DIUP_PKT_DATA_MAX : remain[10:0];

	// register read mux
	always_comb
	begin
		rd_mapped = 1'b1;
		rd_value = 32'h00000000;
		case (paddr)
			DIUP_REG_CTRL: rd_value = {25'h0000000, s.saved_valid, s.phase != DIUP_IDLE, 2'b00,
				s.skip_check, s.tcp_en, s.udp_en};
			DIUP_REG_STATUS: rd_value = {s.frame_sequence_count, s.packet_sequence_number};
			DIUP_REG_DEST_IP: rd_value = s.staged_ip;
			DIUP_REG_DEST_PORT: rd_value = {16'h0000, s.staged_port};
			DIUP_REG_IMG_DIMS: rd_value = {s.pixel_columns, s.pixel_rows};
			DIUP_REG_IMG_FORMAT: rd_value = {s.payload_layout_setting, s.pixel_byte_size, s.channel_count};
			DIUP_REG_CODE_REV: rd_value = {16'h0000, s.code_revision_register};
			DIUP_REG_ACTIVE_IP: rd_value = s.active_ip;
			DIUP_REG_ACTIVE_PORT: rd_value = {16'h0000, s.active_port};
			default: rd_mapped = 1'b0;
		endcase
	end

	// next state of the whole block
	always_comb
	begin
		next_s = s;
		mem_we = 1'b0;
		mem_waddr = s.idx;
		mem_wdata = fill_byte;

		// apb: answer latched in setup, write lands in access
		if (psel & ~penable)
		begin
			next_s.prdata = rd_mapped ? rd_value : 32'h00000000;
			next_s.pslverr = ~rd_mapped;
		end
		if (psel & penable & pwrite & ~s.pslverr)
		begin
			case (paddr)
				DIUP_REG_CTRL:
				begin
					next_s.udp_en = pwdata[DIUP_CTRL_UDP];
					next_s.tcp_en = pwdata[DIUP_CTRL_TCP];
					next_s.skip_check = pwdata[DIUP_CTRL_SKIP];
					// staged settings only reach the link through save, then reconnect
					if (pwdata[DIUP_CTRL_SAVE])
					begin
						next_s.saved_ip = s.staged_ip;
						next_s.saved_port = s.staged_port;
						next_s.saved_valid = 1'b1;
					end
					if (pwdata[DIUP_CTRL_RECONNECT] & s.saved_valid)
					begin
						next_s.active_ip = s.saved_ip;
						next_s.active_port = s.saved_port;
					end
				end
				DIUP_REG_DEST_IP: next_s.staged_ip = pwdata;
				DIUP_REG_DEST_PORT: next_s.staged_port = pwdata[15:0];
				DIUP_REG_IMG_DIMS:
				begin
					next_s.pixel_columns = pwdata[31:16];
					next_s.pixel_rows = pwdata[15:0];
				end
				DIUP_REG_IMG_FORMAT:
				begin
					next_s.channel_count = pwdata[7:0];
					next_s.pixel_byte_size = pwdata[15:8];
					next_s.payload_layout_setting = pwdata[31:16];
				end
				DIUP_REG_CODE_REV: next_s.code_revision_register = pwdata[15:0];
				default: next_s.udp_en = s.udp_en;
			endcase
		end

		// drained output byte leaves the register
		if (s.out_valid & out_ready)
		begin
			next_s.out_valid = 1'b0;
			next_s.out_sop = 1'b0;
			next_s.out_last = 1'b0;
		end

		case (s.phase)
			DIUP_IDLE:
			begin
				// a frame that arrives while streaming is off is dropped
				if (frame_start & s.udp_en)
				begin
					next_s.stamp = frame_timestamp_us;
					next_s.main_board_temperature = main_temp_celsius + DIUP_TEMP_OFFSET;
					next_s.illumination_board_temperature = illum_temp_celsius + DIUP_TEMP_OFFSET;
					next_s.frame_total_bytes = DIUP_IMG_HDR_BYTES + image_bytes;
					next_s.frame_offset = 32'h00000000;
					next_s.packet_sequence_number = 16'h0000;
					next_s.packet_payload_length = (DIUP_IMG_HDR_BYTES + image_bytes > 32'(DIUP_PKT_DATA_MAX))
						? DIUP_PKT_DATA_MAX : 11'(DIUP_IMG_HDR_BYTES + image_bytes);
					next_s.packet_checksum = DIUP_CRC32_SEED;
					next_s.header_checksum = DIUP_CRC16_SEED;
					next_s.idx = 11'h000;
					next_s.phase = DIUP_HEAD;
				end
			end
			DIUP_HEAD:
			begin
				// header goes through the checksum first, in wire order
				next_s.packet_checksum = diup_crc32_step(s.packet_checksum,
					diup_pick_byte(head_vec_zero, s.idx[5:0]));
				next_s.idx = s.idx + 11'h001;
				if (s.idx == DIUP_PKT_HDR_BYTES - 11'h001)
				begin
					next_s.idx = 11'h000;
					next_s.phase = DIUP_FILL;
				end
			end
			DIUP_FILL:
			begin
				if (fill_ok)
				begin
					mem_we = 1'b1;
					next_s.packet_checksum = diup_crc32_step(s.packet_checksum, fill_byte);
					if (s.frame_offset >= DIUP_IH_CRC_FIRST && s.frame_offset < DIUP_IH_CRC_OFS)
					begin
						next_s.header_checksum = diup_crc16_step(s.header_checksum, fill_byte);
					end
					next_s.frame_offset = s.frame_offset + 32'h00000001;
					next_s.idx = s.idx + 11'h001;
					if (s.idx == s.packet_payload_length - 11'h001)
					begin
						next_s.idx = 11'h000;
						next_s.phase = DIUP_SEND;
					end
				end
			end
			DIUP_SEND:
			begin
				if (load_ok)
				begin
					next_s.out_valid = 1'b1;
					next_s.out_sop = s.idx == 11'h000;
					next_s.out_last = s.idx == send_end;
					// data section starts right after the 32-byte header
					next_s.out_data = (s.idx < DIUP_PKT_HDR_BYTES)
						? diup_pick_byte(head_vec_final, s.idx[5:0]) : mem_rdata;
					next_s.idx = s.idx + 11'h001;
					if (s.idx == send_end)
					begin
						next_s.idx = 11'h000;
						next_s.packet_sequence_number = s.packet_sequence_number + 16'h0001;
						next_s.packet_checksum = DIUP_CRC32_SEED;
						if (s.frame_offset == s.frame_total_bytes)
						begin
							next_s.frame_sequence_count = s.frame_sequence_count + 16'h0001;
							next_s.phase = DIUP_IDLE;
						end
						else
						begin
							next_s.packet_payload_length = next_len;
							next_s.phase = DIUP_HEAD;
						end
					end
				end
			end
			default: next_s.phase = DIUP_IDLE;
		endcase
	end

	// state register with factory defaults
	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			s <= '0;
			s.udp_en <= 1'b1;
			s.tcp_en <= 1'b1;
			s.staged_ip <= DIUP_DEST_IP_RST;
			s.staged_port <= DIUP_DEST_PORT_RST;
			s.saved_ip <= DIUP_DEST_IP_RST;
			s.saved_port <= DIUP_DEST_PORT_RST;
			s.active_ip <= DIUP_DEST_IP_RST;
			s.active_port <= DIUP_DEST_PORT_RST;
		end
		else
		begin
			s <= next_s;
		end
	end

	// payload buffer, no reset needed: bytes are always written before read
	always_ff @(posedge ref_clk)
	begin
		if (mem_we)
		begin
			pkt_mem[mem_waddr] <= mem_wdata;
		end
	end

endmodule
`default_nettype wire

// >>> tb/diup_packetizer_sva.sv
// port assertions for the depth image udp packetizer
`timescale 1ns/1ps
`default_nettype none
module diup_packetizer_sva (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_b,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pready,
	// packet stream
	input wire logic [7:0] out_data,
	input wire logic out_valid,
	input wire logic out_ready,
	input wire logic out_sop,
	input wire logic out_last,
	// settings in force
	input wire logic udp_stream_enable,
	input wire logic tcp_listen_enable,
	input wire logic [31:0] dest_ip,
	input wire logic [15:0] dest_port
);
	logic [10:0] bc;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_b);

	// byte position in the current packet
	always_ff @(posedge ref_clk or negedge rst_b)
		if (!rst_b)
			bc <= 11'h000;
		else if (out_valid && out_ready)
			bc <= out_last ? 11'h000 : bc + 11'h001;

	chk_sop_at_start: assert property (out_valid && out_sop |-> bc == 11'h000)
		else $error("packet start off byte zero");
	chk_pkt_max_len: assert property (out_valid |-> bc < 11'h598)
		else $error("packet longer than allowed");
	chk_version_bytes: assert property (out_valid && bc < 11'h002 |-> out_data == {7'h00, bc[0]})
		else $error("protocol version byte wrong");
	chk_reserved_zero: assert property (out_valid && bc >= 11'h010 && bc < 11'h020 && bc != 11'h013 |-> out_data == 8'h00)
		else $error("reserved header byte not zero");
	chk_flag_bits: assert property (out_valid && bc == 11'h013 |-> out_data[7:1] == 7'h00)
		else $error("undefined flag set");
	chk_last_after_hdr: assert property (out_valid && out_last |-> bc >= 11'h020)
		else $error("packet ends inside header");
	chk_hold_byte: assert property (out_valid && !out_ready |=> out_valid && $stable(out_data) && $stable(out_last))
		else $error("byte dropped while stalled");
	chk_reset_defaults: assert property ($rose(rst_b) |-> udp_stream_enable && tcp_listen_enable && dest_ip == 32'he0000001 && dest_port == 16'h2712)
		else $error("factory defaults missing");
	chk_net_held: assert property (!(psel && penable && pwrite && paddr == 8'h00 && pwdata[4]) |=> $stable(dest_ip) && $stable(dest_port))
		else $error("address changed without reconnect");
	chk_ready_access: assert property (pready == (psel && penable))
		else $error("pready outside access phase");
endmodule
bind diup_packetizer diup_packetizer_sva u_sva (.ref_clk(ref_clk), .rst_b(rst_b), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .out_data(out_data), .out_valid(out_valid),
	.out_ready(out_ready), .out_sop(out_sop), .out_last(out_last), .udp_stream_enable(udp_stream_enable),
	.tcp_listen_enable(tcp_listen_enable), .dest_ip(dest_ip), .dest_port(dest_port));
`default_nettype wire

// >>> tb/diup_client.sv
// network client model: takes packets, checks crc, rebuilds frame
`timescale 1ns/1ps
`default_nettype none
module diup_client (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_b,
	// packet stream
	input wire logic [7:0] out_data,
	input wire logic out_valid,
	input wire logic out_sop,
	input wire logic out_last,
	output logic out_ready,
	// stall control
	input wire logic slow
);
	logic [7:0] pb [0:1431];
	logic [7:0] hd [0:1][0:31];
	logic [7:0] fb [0:2047];
	int plen [0:1];
	int npk = 0;
	int crc_bad = 0;
	int nb = 0;
	logic tgl = 1'b0;
	logic skip_data = 1'b0;

	// a slow client takes a byte only every other cycle
	assign out_ready = !slow || tgl;

	// check one packet, then file it by its sequence number
	task automatic file_pkt();
		logic [31:0] c;
		int s;
		c = 32'h0fffffff;
		for (int i = 0; i < nb; i++)
			for (int b = 7; b >= 0; b--)
				c = (c[31] ^ ((i >= 12 && i < 16) ? 1'b0 : pb[i][b])) ? ((c << 1) ^ 32'h04c11db7) : (c << 1);
		if (c !== {pb[12], pb[13], pb[14], pb[15]})
			crc_bad++;
		// packet crc covers header and data, so the flag only gets noted
		skip_data = pb[19][0];
		s = pb[5][0];
		plen[s] = nb;
		for (int i = 0; i < 32; i++)
			hd[s][i] = pb[i];
		for (int i = 32; i < nb; i++)
			fb[s * 1400 + i - 32] = pb[i];
		npk++;
	endtask

	// byte capture
	always @(posedge ref_clk)
	begin
		tgl <= !tgl;
		if (rst_b && out_valid && out_ready)
		begin
			if (out_sop)
				nb = 0;
			if (nb < 1432)
				pb[nb] = out_data;
			nb++;
			if (out_last)
				file_pkt();
		end
	end
endmodule
`default_nettype wire

// >>> tb/diup_packetizer_tb_top.sv
// testbench top for the depth image udp packetizer
`timescale 1ns/1ps
`default_nettype none
module diup_packetizer_tb_top;
	logic ref_clk = 1'b0;
	logic rst_b = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic frame_start = 1'b0;
	logic pix_valid = 1'b0;
	logic slow = 1'b0;
	logic [15:0] pn = 16'h0;
	logic [31:0] prdata, dest_ip, rd;
	logic [15:0] dest_port;
	logic [7:0] out_data, pix_data;
	logic pready, pslverr, pix_ready, out_valid, out_sop, out_last, out_ready, err;
	logic udp_stream_enable, tcp_listen_enable;
	int fail_count = 0;
	int checks_done = 0;

	function automatic logic [7:0] pat(input logic [15:0] i);
		return i[7:0] ^ {5'h00, i[10:8]};
	endfunction

	// pixel source advances on every accepted byte
	assign pix_data = pat(pn);
	always @(posedge ref_clk)
		if (frame_start)
			pn <= 16'h0;
		else if (pix_valid && pix_ready)
			pn <= pn + 16'h1;

	always #5 ref_clk = ~ref_clk;

	diup_packetizer dut (.ref_clk(ref_clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.frame_start(frame_start), .frame_timestamp_us(32'h12345678), .main_temp_celsius(8'h19),
		.illum_temp_celsius(8'h1e), .pix_data(pix_data), .pix_valid(pix_valid), .pix_ready(pix_ready),
		.out_data(out_data), .out_valid(out_valid), .out_ready(out_ready), .out_sop(out_sop),
		.out_last(out_last), .udp_stream_enable(udp_stream_enable), .tcp_listen_enable(tcp_listen_enable),
		.dest_ip(dest_ip), .dest_port(dest_port));
	diup_client cl (.ref_clk(ref_clk), .rst_b(rst_b), .out_data(out_data), .out_valid(out_valid),
		.out_sop(out_sop), .out_last(out_last), .out_ready(out_ready), .slow(slow));

	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e)
		begin
			fail_count++;
			$display("BAD %s expected %h seen %h", n, e, g);
		end
	endtask

	// big-endian field from a packet header, or from the frame when p is 2
	function automatic logic [31:0] gv(input int p, input int o, input int n);
		logic [31:0] v;
		v = 32'h0;
		for (int k = 0; k < n; k++)
			v = {v[23:0], (p == 2) ? cl.fb[o + k] : cl.hd[p % 2][o + k]};
		return v;
	endfunction

	// one apb transfer; waits up to 50 cycles for pready, counts a failure if it never comes
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge ref_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge ref_clk);
			n++;
		end
		while (pready !== 1'b1 && n < 50);
		if (pready !== 1'b1)
			fail_count++;
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic do_reset();
		rst_b <= 1'b0;
		repeat (4) @(posedge ref_clk);
		rst_b <= 1'b1;
		@(posedge ref_clk);
	endtask

	task automatic t_defaults();
		chk("udp_en", 1, udp_stream_enable);
		chk("tcp_en", 1, tcp_listen_enable);
		chk("ip", 32'he0000001, dest_ip);
		chk("port", 32'h2712, dest_port);
		apb(0, 8'h00, 0);
		chk("ctrl", 32'h3, rd);
		apb(1, 8'h3c, 32'h1);
		chk("unmapped", 1, err);
	endtask

	// staged address must wait for save and reconnect
	task automatic t_net();
		apb(1, 8'h08, 32'h0a00002a);
		apb(1, 8'h0c, 32'h271a);
		apb(1, 8'h00, 32'h13);
		repeat (2) @(posedge ref_clk);
		chk("ip_nosave", 32'he0000001, dest_ip);
		apb(1, 8'h00, 32'h0b);
		repeat (2) @(posedge ref_clk);
		chk("ip_saved", 32'he0000001, dest_ip);
		apb(1, 8'h00, 32'h13);
		repeat (2) @(posedge ref_clk);
		chk("ip_new", 32'h0a00002a, dest_ip);
		chk("port_new", 32'h271a, dest_port);
		apb(0, 8'h1c, 0);
		chk("active_ip_rd", 32'h0a00002a, rd);
		do_reset();
		chk("ip_reboot", 32'he0000001, dest_ip);
	endtask

	// 40x35 one-byte pixels: 1464 frame bytes in two packets
	task automatic t_frame(input logic sk, input logic sl, input logic [15:0] fc);
		int n0, bad;
		logic [15:0] c;
		logic [7:0] z;
		apb(1, 8'h10, {16'h0028, 16'h0023});
		apb(1, 8'h14, 32'h01020101);
		apb(1, 8'h18, 32'h0a5c);
		apb(1, 8'h00, {29'h0, sk, 2'b11});
		n0 = cl.npk;
		slow <= sl;
		frame_start <= 1'b1;
		@(posedge ref_clk);
		frame_start <= 1'b0;
		pix_valid <= 1'b1;
		for (int k = 0; k < 20000 && cl.npk < n0 + 2; k++)
			@(posedge ref_clk);
		if (cl.npk < n0 + 2)
			fail_count++;
		repeat (2) @(posedge ref_clk);
		pix_valid <= 1'b0;
		for (int p = 0; p < 2; p++)
		begin
			chk("ver", 32'h1, gv(p, 0, 2));
			chk("fcnt", fc, gv(p, 2, 2));
			chk("seq", p, gv(p, 4, 2));
			chk("dlen", p ? 64 : 1400, gv(p, 6, 2));
			chk("plen", p ? 96 : 1432, cl.plen[p]);
			chk("fsize", 1464, gv(p, 8, 4));
			chk("flags", sk, gv(p, 16, 4));
			chk("rsv", 0, gv(p, 20, 4) | gv(p, 24, 4) | gv(p, 28, 4));
		end
		chk("crc_bad", 0, cl.crc_bad);
		chk("mark", 32'hffff0003, gv(2, 0, 4));
		chk("dims", 32'h00280023, gv(2, 4, 4));
		chk("fmt", 32'h01010102, gv(2, 8, 4));
		chk("stamp", 32'h12345678, gv(2, 12, 4));
		chk("img_fcnt", fc, gv(2, 16, 2));
		chk("temps", 32'h4b50, gv(2, 26, 2));
		chk("rev", 32'h0a5c, gv(2, 28, 2));
		c = 16'h0;
		z = 8'h00;
		for (int i = 2; i < 62; i++)
		begin
			for (int b = 7; b >= 0; b--)
				c = (c[15] ^ cl.fb[i][b]) ? ((c << 1) ^ 16'h1021) : (c << 1);
			if (i >= 18 && (i < 26 || i > 29))
				z = z | cl.fb[i];
		end
		chk("img_crc", c, gv(2, 62, 2));
		chk("img_rsv", 0, z);
		bad = 0;
		for (int i = 0; i < 1400; i++)
			if (cl.fb[64 + i] !== pat(16'(i)))
				bad++;
		chk("pixels", 0, bad);
	endtask

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	initial
	begin
		do_reset();
		t_defaults();
		t_net();
		t_frame(1'b0, 1'b0, 16'h0);
		t_frame(1'b1, 1'b1, 16'h1);
		wrap_up();
	end

	// the run needs under 10000 cycles
	initial
	begin
		#400000;
		fail_count++;
		wrap_up();
	end
endmodule
`default_nettype wire
